// [hdl/ccc_capture_control.sv]
// capture control register for channels 0 to 3, counter, capture registers
// assumes capture inputs already synchronous to clk and an AXI4-Lite master
//
// What this block does
// - edge code: fall, rise, both, disabled
// - selected edge copies counter into capture
// - skip bit routes input around filter
// - three-bit filter clock select per channel
// - channel 3 fields at 31:29, 26, 25:24
// - channel 2 fields at 23:21, 18, 17:16
// - channel 1 fields at 15:13, 10, 9:8
// - channel 0 fields at 7:5, 2, 1:0
// - 32-bit counter from zero, wraps around
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps

module ccc_capture_control
  import ccc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [3:0]  capture_in,
  input  wire logic [7:0]  filter_tick,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [3:0]       capture_event
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0]      control;
    logic [31:0]      counter;
    logic [3:0][31:0] capture;
    logic [3:0]       level;
    logic [3:0][1:0]  stable;
    logic [3:0]       prev;
    logic [3:0]       event_out;
    logic             aw_held;
    logic [7:0]       aw_addr;
    logic             w_held;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             b_valid;
    logic [1:0]       b_resp;
    logic             r_valid;
    logic [31:0]      r_data;
    logic [1:0]       r_resp;
  } ccc_state_t;

  ccc_state_t st_reg;
  ccc_state_t st_next;

  // ----------------------------------------------------------------
  // edge qualification
  // ----------------------------------------------------------------
  function automatic logic ccc_edge_hit(input logic [1:0] mode, input logic old_v,
                                        input logic new_v);
    logic hit;
    hit = 1'b0;
    case (mode)
      CCC_EDGE_FALL: hit = old_v & ~new_v;
      CCC_EDGE_RISE: hit = ~old_v & new_v;
      CCC_EDGE_BOTH: hit = old_v ^ new_v;
      default:       hit = 1'b0;
    endcase
    return hit;
  endfunction

  logic [3:0] chan_in;
  logic [3:0] tick_sel;
  logic [3:0] chan_skip;
  logic [3:0][1:0] chan_edge;

  genvar g;
  generate
    for (g = 0; g < CCC_CHANNELS; g++) begin : g_chan
      localparam int BASE = g * CCC_LANE_BITS;
      logic [2:0] sel;
      // lane layout puts channel n in byte n
      assign sel          = st_reg.control[BASE + CCC_SEL_LSB +: 3];
      assign chan_skip[g] = st_reg.control[BASE + CCC_SKIP_BIT];
      assign chan_edge[g] = st_reg.control[BASE + CCC_EDGE_LSB +: 2];
      assign tick_sel[g]  = filter_tick[sel];
      assign chan_in[g]   = chan_skip[g] ? capture_in[g] : st_reg.level[g];
    end
  endgenerate

  logic [7:0] wr_addr;
  logic [31:0] wr_mask;
  logic        do_write;
  logic        do_read;

  always_comb begin
    st_next = st_reg;
    wr_addr = st_reg.aw_held ? st_reg.aw_addr : s_axi_awaddr;
    wr_mask = {{8{st_reg.w_held ? st_reg.w_strb[3] : s_axi_wstrb[3]}},
               {8{st_reg.w_held ? st_reg.w_strb[2] : s_axi_wstrb[2]}},
               {8{st_reg.w_held ? st_reg.w_strb[1] : s_axi_wstrb[1]}},
               {8{st_reg.w_held ? st_reg.w_strb[0] : s_axi_wstrb[0]}}};
    do_write = (st_reg.aw_held | s_axi_awvalid) & (st_reg.w_held | s_axi_wvalid)
               & ~st_reg.b_valid;
    do_read  = s_axi_arvalid & ~st_reg.r_valid;

    // ----------------------------------------------------------------
    // counter, filter and capture
    // ----------------------------------------------------------------
    st_next.counter = st_reg.counter + 32'h0000_0001;
    st_next.prev    = chan_in;
    for (int i = 0; i < CCC_CHANNELS; i++) begin
      if (capture_in[i] == st_reg.level[i]) begin
        st_next.stable[i] = 2'h0;
      end else if (tick_sel[i]) begin
        if (st_reg.stable[i] == CCC_FILTER_TICKS - 2'h1) begin
          st_next.level[i]  = capture_in[i];
          st_next.stable[i] = 2'h0;
        end else begin
          st_next.stable[i] = st_reg.stable[i] + 2'h1;
        end
      end
      st_next.event_out[i] = ccc_edge_hit(chan_edge[i], st_reg.prev[i], chan_in[i]);
      if (st_next.event_out[i]) begin
        st_next.capture[i] = st_reg.counter;
      end
    end

    // ----------------------------------------------------------------
    // write channel
    // ----------------------------------------------------------------
    // a pending response refuses address and data, so nothing is latched then
    if (s_axi_awvalid & ~st_reg.aw_held & ~st_reg.b_valid & ~do_write) begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid & ~st_reg.w_held & ~st_reg.b_valid & ~do_write) begin
      st_next.w_held = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      st_next.aw_held = 1'b0;
      st_next.w_held  = 1'b0;
      st_next.b_valid = 1'b1;
      st_next.b_resp  = CCC_RESP_OKAY;
      if (wr_addr[7:2] == CCC_OFF_CONTROL[7:2]) begin
        st_next.control = ((st_reg.control & ~wr_mask) |
                           ((st_reg.w_held ? st_reg.w_data : s_axi_wdata) & wr_mask))
                          & CCC_CONTROL_MASK;
      end else if (wr_addr[7:2] == CCC_OFF_COUNTER[7:2]) begin
        st_next.b_resp = CCC_RESP_OKAY;
      end else if (wr_addr[7:4] == CCC_OFF_CAPTURE0[7:4]) begin
        st_next.b_resp = CCC_RESP_OKAY;
      end else begin
        st_next.b_resp = CCC_RESP_SLVERR;
      end
    end else if (st_reg.b_valid & s_axi_bready) begin
      st_next.b_valid = 1'b0;
    end

    // ----------------------------------------------------------------
    // read channel
    // ----------------------------------------------------------------
    if (do_read) begin
      st_next.r_valid = 1'b1;
      st_next.r_resp  = CCC_RESP_OKAY;
      if (s_axi_araddr[7:2] == CCC_OFF_CONTROL[7:2]) begin
        st_next.r_data = st_reg.control;
      end else if (s_axi_araddr[7:2] == CCC_OFF_COUNTER[7:2]) begin
        st_next.r_data = st_reg.counter;
      end else if (s_axi_araddr[7:4] == CCC_OFF_CAPTURE0[7:4]) begin
        st_next.r_data = st_reg.capture[s_axi_araddr[3:2]];
      end else begin
        st_next.r_data = 32'h0000_0000;
        st_next.r_resp = CCC_RESP_SLVERR;
      end
    end else if (st_reg.r_valid & s_axi_rready) begin
      st_next.r_valid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // register update
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg         <= '0;
      st_reg.control <= CCC_CONTROL_RESET;
      st_reg.counter <= CCC_COUNTER_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // bus outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = ~st_reg.aw_held & ~st_reg.b_valid;
  assign s_axi_wready  = ~st_reg.w_held & ~st_reg.b_valid;
  assign s_axi_bvalid  = st_reg.b_valid;
  assign s_axi_bresp   = st_reg.b_resp;
  assign s_axi_arready = ~st_reg.r_valid;
  assign s_axi_rvalid  = st_reg.r_valid;
  assign s_axi_rdata   = st_reg.r_data;
  assign s_axi_rresp   = st_reg.r_resp;
  assign capture_event = st_reg.event_out;

endmodule

// [hdl/ccc_pkg.sv]
// constants for the four-channel capture control block
// assumes a single 125 MHz clock and an AXI4-Lite register bus
package ccc_pkg;

  localparam int          CCC_CHANNELS      = 4;
  localparam logic [7:0]  CCC_OFF_CONTROL   = 8'h04;
  localparam logic [7:0]  CCC_OFF_COUNTER   = 8'h0C;
  localparam logic [7:0]  CCC_OFF_CAPTURE0  = 8'h10;
  localparam logic [31:0] CCC_CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] CCC_CONTROL_MASK  = 32'hE7E7_E7E7;
  localparam logic [31:0] CCC_COUNTER_RESET = 32'h0000_0000;
  localparam int          CCC_LANE_BITS     = 8;
  localparam int          CCC_SEL_LSB       = 5;
  localparam int          CCC_SKIP_BIT      = 2;
  localparam int          CCC_EDGE_LSB      = 0;
  localparam logic [1:0]  CCC_EDGE_FALL     = 2'h0;
  localparam logic [1:0]  CCC_EDGE_RISE     = 2'h1;
  localparam logic [1:0]  CCC_EDGE_BOTH     = 2'h2;
  localparam logic [1:0]  CCC_EDGE_OFF      = 2'h3;
  localparam logic [1:0]  CCC_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  CCC_RESP_SLVERR   = 2'h2;
  // filter: input must hold for this many filter-clock ticks
  localparam logic [1:0]  CCC_FILTER_TICKS  = 2'h3;

  typedef enum logic [2:0] {
    CCC_IDLE = 3'h1,
    CCC_BUSY = 3'h2,
    CCC_RESP = 3'h4
  } ccc_bus_state_t;

endpackage

// [verification/ccc_capture_control_test.sv]
// self-checking bench for the capture control block
// assumes the input model and the bound checker are compiled first
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
  $display("wrong value at %0t: got %h", $time, a); end end
module ccc_capture_control_test;
  import ccc_pkg::*;
  logic clk = 0, sys_rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr = CCC_OFF_CONTROL, s_axi_araddr = '0, filter_tick, tick_en = 8'hFF;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, cyc, d, exp_cap [4];
  logic [3:0] s_axi_wstrb = 4'hF, lvl = '0, capture_in, capture_event;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] s;
  logic [33:0] expq [$];
  logic [1:0] bq [$];
  int fails = 0, n_compared = 0, timer = 0, ev_cnt [4] = '{0, 0, 0, 0}, n_exp [4] = '{1, 1, 2, 0};
  ccc_capture_control ccc_capture_control_i (.*);
  ccc_input_model ccc_input_model_i (.lvl(lvl), .tick_en(tick_en), .clk(clk),
    .capture_in(capture_in),
    .filter_tick(filter_tick));
  always #4 clk = ~clk;
  always @(posedge clk) cyc <= sys_rst ? 32'h0 : cyc + 32'h1;
  // ------------------------------------------------
  // monitor: events and read results
  // ------------------------------------------------
  always @(negedge clk) begin
    for (int i = 0; i < 4; i++)
      if (capture_event[i] === 1'b1) begin
        exp_cap[i] <= cyc - 32'h1;
        ev_cnt[i] <= ev_cnt[i] + 1;
      end
    if (s_axi_rvalid && s_axi_rready)
      `CHK({s_axi_rresp, s_axi_rdata}, expq.pop_front())
    if (s_axi_bvalid && s_axi_bready)
      `CHK(s_axi_bresp, bq.pop_front())
    if (++timer > 20000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic wr(input logic [31:0] v, input logic [7:0] a, input logic [1:0] r);
    logic ga, gw, gb;
    @(posedge clk);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clk);
      ga = s_axi_awvalid & s_axi_awready;
      gw = s_axi_wvalid & s_axi_wready;
      gb = s_axi_bvalid;
      @(posedge clk);
      if (ga) s_axi_awvalid <= 1'b0;
      if (gw) s_axi_wvalid <= 1'b0;
      if (gb) s_axi_bready <= 1'b0;
    end while (!gb);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    logic ga, gb;
    @(posedge clk);
    expq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clk);
      ga = s_axi_arvalid & s_axi_arready;
      gb = s_axi_rvalid;
      @(posedge clk);
      if (ga) s_axi_arvalid <= 1'b0;
      if (gb) s_axi_rready <= 1'b0;
    end while (!gb);
  endtask
  task automatic pulse(input int ch, input int hi);
    @(posedge clk);
    lvl[ch] <= 1'b1;
    repeat (hi) @(posedge clk);
    lvl[ch] <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic wrap_up;
    $display("compared %0d, wrong %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    void'($urandom(32'h97C2637E));
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rd(CCC_OFF_CONTROL, 34'h0);
    rd(8'h08, {CCC_RESP_SLVERR, 32'h0});
    d = $urandom;
    wr(d, CCC_OFF_CONTROL, CCC_RESP_OKAY);
    wr(~d, 8'h08, CCC_RESP_SLVERR);
    rd(CCC_OFF_CONTROL, {2'h0, d & CCC_CONTROL_MASK});
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(CCC_OFF_CONTROL, 34'h0);
    $display("register test done");
    for (int ch = 0; ch < 4; ch++)
      for (int code = 0; code < 4; code++) begin
        wr((32'h4 + code) << (8 * ch), CCC_OFF_CONTROL, CCC_RESP_OKAY);
        ev_cnt[ch] = 0;
        pulse(ch, 3);
        `CHK(ev_cnt[ch], n_exp[code])
        if (code < 3) rd(CCC_OFF_CAPTURE0 + 8'(4 * ch), {2'h0, exp_cap[ch]});
      end
    $display("edge test done");
    s = 3'($urandom_range(7));
    wr({24'h0, s, 5'h01}, CCC_OFF_CONTROL, CCC_RESP_OKAY);
    ev_cnt[0] = 0;
    tick_en <= ~(8'h01 << s);
    pulse(0, 40);
    `CHK(ev_cnt[0], 0)
    tick_en <= 8'hFF;
    pulse(0, 4);
    `CHK(ev_cnt[0], 0)
    pulse(0, 40);
    `CHK(ev_cnt[0], 1)
    $display("filter test done");
    wrap_up();
  end
endmodule

// [verification/ccc_input_model.sv]
// external capture sources and filter ticks
// assumes the bench sets wanted levels on lvl
`timescale 1ns/1ps
module ccc_input_model (
  input  wire logic [3:0] lvl,
  input  wire logic [7:0] tick_en,
  input  wire logic       clk,
  output logic      [3:0] capture_in,
  output logic      [7:0] filter_tick
);
  logic [2:0] phase_reg = 3'h0;
  initial capture_in = 4'h0;
  initial filter_tick = 8'h00;
  // each filter source ticks once in eight cycles unless masked off
  always @(posedge clk) begin
    phase_reg <= phase_reg + 3'h1;
    capture_in <= lvl;
    filter_tick <= (8'h01 << phase_reg) & tick_en;
  end
endmodule

// [verification/ccc_props.sv]
// register bus checker for the capture control block
// assumes it is bound onto ccc_capture_control
`timescale 1ns/1ps
module ccc_props
  import ccc_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------
  // bus checks
  // ------------------------------------------------
  a_reset_idle: assert property ($fell(sys_rst) |-> !s_axi_bvalid && !s_axi_rvalid)
    else $error("bus not idle after reset");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken with response pending");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> s_axi_bvalid) else $error("no write response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read response");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held too long");
  a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response held too long");
  a_ctrl_reserved: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr == CCC_OFF_CONTROL |=> (s_axi_rdata & ~CCC_CONTROL_MASK) == 32'h0
    && s_axi_rresp == CCC_RESP_OKAY) else $error("reserved control bits set");
  a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr == 8'h08 |=> s_axi_rresp == CCC_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule
bind ccc_capture_control ccc_props ccc_props_i (.*);
